// [hdl/ivmc_regs.svh]
/*
 * constants of the vectored interrupt controller: counts, line positions,
 * exception numbers, priority ranks and vector base.
 * assumes inclusion by bare name from the package and the design.
 */
`ifndef IVMC_REGS_SVH
`define IVMC_REGS_SVH
`define IVMC_NUM_IRQ      64
`define IVMC_NUM_UNUSED   25
`define IVMC_NUM_SYS      16
`define IVMC_NUM_W        7
`define IVMC_PRIO_LEVELS  8
`define IVMC_PRIO_W       3
`define IVMC_RANK_W       4
`define IVMC_RANK_NMI     4'h0
`define IVMC_RANK_HARD    4'h1
`define IVMC_RANK_OFS     4'h2
`define IVMC_RANK_IDLE    4'hf
`define IVMC_NEST_MIN     10
`define IVMC_VEC_BASE     32'h0000_0040
`define IVMC_EXC_NMI      7'h02
`define IVMC_EXC_HARD     7'h03
`define IVMC_EXC_SVC      7'h0b
`define IVMC_EXC_PEND     7'h0e
`define IVMC_EXC_TICK     7'h0f
`define IVMC_IRQ_BASE     7'h10
`define IVMC_LN_LVD       0
`define IVMC_LN_SCLK      1
`define IVMC_LN_XTAL      2
`define IVMC_LN_WDOG      3
`define IVMC_LN_TIMER0    5
`define IVMC_LN_TIMER_UNIT8_IRQ    13
`define IVMC_LN_PORT      16
`define IVMC_LN_MPWM      24
`define IVMC_LN_SPI       32
`define IVMC_LN_I2C       36
`define IVMC_LN_UART      38
`define IVMC_LN_ADC       43
`define IVMC_LN_COMP      46
`define IVMC_LN_RSVD      50
`endif

// [hdl/ivmc_pkg.sv]
/*
 * types of the vectored interrupt controller.
 * assumes ivmc_regs.svh on the include path.
 */
`include "ivmc_regs.svh"
package ivmc_pkg;
    // peripheral request lines, grouped by source kind
    typedef struct packed {
        logic [3:0] comparator_irq;
        logic [2:0] converter_irq;
        logic [3:0] uart_irq;
        logic [1:0] i2c_irq;
        logic [1:0] spi_irq;
        logic [5:0] motor_pwm_irq;
        logic [7:0] port_irq;
        logic [1:0] timer_unit8_9_irq;
        logic [3:0] timer_unit0_3_irq;
        logic       watchdog_irq;
        logic       crystal_fail_irq;
        logic       system_clock_fail_irq;
        logic       low_voltage_detect_irq;
    } ivmc_periph_t;
    // system exception requests, one-cycle pulses
    typedef struct packed {
        logic system_tick_exception;
        logic pendable_service_exception;
        logic svcall;
        logic hard_fault;
        logic nmi;
    } ivmc_sys_t;
    // offer to the processor core
    typedef struct packed {
        logic                    valid;
        logic [`IVMC_NUM_W-1:0]  num;
        logic [31:0]             vector;
        logic                    tail_chain;
    } ivmc_core_t;
endpackage

// [hdl/ivmc_nested_vector_controller.sv]
/*
 * nested vectored interrupt controller: line mapping, pending state,
 * priority arbitration, nesting stack and vectored offer to the core.
 * assumes one clock, synchronous inputs, and a core that pulses taken
 * for the offer it accepts and return when a handler ends.
 */
// Operation
// - 64 peripheral lines, 25 unused, plus 16 system slots, each own vector
// - eight priority levels arbitrate pending requests
// - group split divides priority into preempting part and sub-priority
// - request needs source enable and controller enable to become active
// - software can set pending directly; system reset request is passed on
// - track nesting, tail-chain on handler end, late arrival takes over
// - peripheral n vector at 0x40 plus four times n
// - lines 24 to 29 carry both motor pwm units, normal/protect/overvoltage
// - lines 16 to 23 carry two lines per port, ports a to d
// - spi on 32-33, i2c on 36-37, uarts on 38-41
// - converters on 43-45, comparators on 46-49
// - timers 0-3 on lines 5-8, timers 8-9 on 13-14
// - lines 50 to 63 never assert, slots stay allocated
`timescale 1ns/1ps
`include "ivmc_regs.svh"
module ivmc_nested_vector_controller #(
    parameter int NEST_DEPTH = `IVMC_NEST_MIN
) (
    input  wire logic                               ref_clk_in,
    input  wire logic                               rst_in,
    input  wire ivmc_pkg::ivmc_periph_t             periph_in,
    input  wire logic [`IVMC_NUM_IRQ-1:0]           src_en_in,
    input  wire logic [`IVMC_NUM_IRQ-1:0]           irq_en_in,
    input  wire logic [`IVMC_NUM_IRQ*`IVMC_PRIO_W-1:0] irq_prio_in,
    input  wire logic [3*`IVMC_PRIO_W-1:0]          sys_prio_in,
    input  wire logic [1:0]                         group_split_in,
    input  wire logic [`IVMC_NUM_IRQ-1:0]           sw_pend_set_in,
    input  wire logic [`IVMC_NUM_IRQ-1:0]           sw_pend_clr_in,
    input  wire ivmc_pkg::ivmc_sys_t                sys_in,
    input  wire logic                               sys_reset_req_in,
    input  wire logic                               exc_taken_in,
    input  wire logic                               exc_return_in,
    output ivmc_pkg::ivmc_core_t                    core_out,
    output logic [$clog2(NEST_DEPTH+1)-1:0]         nest_depth_out,
    output logic [`IVMC_NUM_IRQ-1:0]                pending_out,
    output logic                                    sys_reset_out
);
    localparam int DW = $clog2(NEST_DEPTH+1);
    localparam int NS = 5;
    localparam logic [`IVMC_NUM_W-1:0] SYS_NUM [NS] = '{
        `IVMC_EXC_NMI, `IVMC_EXC_HARD, `IVMC_EXC_SVC,
        `IVMC_EXC_PEND, `IVMC_EXC_TICK
    };

    generate
        if (NEST_DEPTH < `IVMC_NEST_MIN || NEST_DEPTH > 15) begin : g_chk
            $error("NEST_DEPTH must lie in 10..15");
        end
    endgenerate

    // lines that carry a source; every other slot stays silent
    function automatic logic [`IVMC_NUM_IRQ-1:0] used_lines();
        logic [`IVMC_NUM_IRQ-1:0] m;
        m = '0;
        m[`IVMC_LN_LVD] = 1'b1;
        m[`IVMC_LN_SCLK] = 1'b1;
        m[`IVMC_LN_XTAL] = 1'b1;
        m[`IVMC_LN_WDOG] = 1'b1;
        m[`IVMC_LN_TIMER0 +: 4] = 4'hf;
        m[`IVMC_LN_TIMER_UNIT8_IRQ +: 2] = 2'h3;
        m[`IVMC_LN_PORT +: 8] = 8'hff;
        m[`IVMC_LN_MPWM +: 6] = 6'h3f;
        m[`IVMC_LN_SPI +: 2] = 2'h3;
        m[`IVMC_LN_I2C +: 2] = 2'h3;
        m[`IVMC_LN_UART +: 4] = 4'hf;
        m[`IVMC_LN_ADC +: 3] = 3'h7;
        m[`IVMC_LN_COMP +: 4] = 4'hf;
        return m;
    endfunction

    localparam logic [`IVMC_NUM_IRQ-1:0] USED = used_lines();

    generate
        if ($countones(USED) != `IVMC_NUM_IRQ - `IVMC_NUM_UNUSED) begin : g_map_chk
            $error("line map must leave the unused slots free");
        end
    endgenerate

    logic [`IVMC_NUM_IRQ-1:0]  line;
    logic [`IVMC_NUM_IRQ-1:0]  req;
    logic [`IVMC_NUM_IRQ-1:0]  req_q;
    logic [`IVMC_NUM_IRQ-1:0]  pend_q;
    logic [`IVMC_NUM_IRQ-1:0]  tk_irq;
    logic [NS-1:0]             sys_pend_q;
    logic [NS-1:0]             tk_sys;
    logic [`IVMC_NUM_W-1:0]    stk_num_q  [NEST_DEPTH];
    logic [`IVMC_RANK_W-1:0]   stk_rank_q [NEST_DEPTH];
    logic [DW-1:0]             depth_q;
    logic [`IVMC_RANK_W-1:0]   cur_rank;
    logic [`IVMC_RANK_W-1:0]   eff_rank;
    logic [6:0]                best_key;
    logic [`IVMC_NUM_W-1:0]    best_num;
    logic                      best_ok;
    logic                      offer;
    logic [31:0]               best_vec;
    logic                      taken;
    ivmc_pkg::ivmc_core_t      core_q;
    logic                      sys_reset_q;

    // rank and sub-priority key of a configurable priority
    function automatic logic [6:0] prio_key(input logic [2:0] p,
                                            input logic [1:0] s);
        logic [2:0] pre;
        logic [2:0] sub;
        pre = p >> s;
        sub = p & 3'((4'h1 << s) - 4'h1);
        return {{1'b0, pre} + `IVMC_RANK_OFS, sub};
    endfunction

    // line map, reserved positions held low
    always_comb begin
        line = '0;
        line[`IVMC_LN_LVD]  = periph_in.low_voltage_detect_irq;
        line[`IVMC_LN_SCLK] = periph_in.system_clock_fail_irq;
        line[`IVMC_LN_XTAL] = periph_in.crystal_fail_irq;
        line[`IVMC_LN_WDOG] = periph_in.watchdog_irq;
        line[`IVMC_LN_TIMER0 +: 4] = periph_in.timer_unit0_3_irq;
        line[`IVMC_LN_TIMER_UNIT8_IRQ +: 2] = periph_in.timer_unit8_9_irq;
        line[`IVMC_LN_PORT +: 8] = periph_in.port_irq;
        line[`IVMC_LN_MPWM +: 6] = periph_in.motor_pwm_irq;
        line[`IVMC_LN_SPI +: 2] = periph_in.spi_irq;
        line[`IVMC_LN_I2C +: 2] = periph_in.i2c_irq;
        line[`IVMC_LN_UART +: 4] = periph_in.uart_irq;
        line[`IVMC_LN_ADC +: 3] = periph_in.converter_irq;
        line[`IVMC_LN_COMP +: 4] = periph_in.comparator_irq;
        line[`IVMC_NUM_IRQ-1:`IVMC_LN_RSVD] = '0;
    end

    assign req = line & src_en_in;
    assign taken = exc_taken_in && core_q.valid && !exc_return_in;

    // one-hot clear of the entry that the core takes
    always_comb begin
        tk_irq = '0;
        tk_sys = '0;
        if (taken) begin
            if (core_q.num >= `IVMC_IRQ_BASE) begin
                tk_irq[6'(core_q.num - `IVMC_IRQ_BASE)] = 1'b1;
            end
            for (int k = 0; k < NS; k++) begin
                if (core_q.num == SYS_NUM[k]) begin
                    tk_sys[k] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            req_q <= '0;
        end else begin
            req_q <= req;
        end
    end

    // pending state, set wins over clear
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~(sw_pend_clr_in | tk_irq))
                      | (((req & ~req_q) | sw_pend_set_in)
                         & USED);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sys_pend_q <= '0;
        end else begin
            sys_pend_q <= (sys_pend_q & ~tk_sys) | sys_in;
        end
    end

    // arbitration across pending and enabled entries
    always_comb begin
        logic [6:0] k_val;
        k_val = 7'h00;
        best_key = 7'h7f;
        best_num = '0;
        best_ok = 1'b0;
        for (int k = 0; k < NS; k++) begin
            case (k)
                0: k_val = {`IVMC_RANK_NMI, 3'h0};
                1: k_val = {`IVMC_RANK_HARD, 3'h0};
                default: k_val = prio_key(sys_prio_in[(k-2)*`IVMC_PRIO_W +: 3],
                                          group_split_in);
            endcase
            if (sys_pend_q[k] && k_val < best_key) begin
                best_key = k_val;
                best_num = SYS_NUM[k];
                best_ok = 1'b1;
            end
        end
        for (int i = 0; i < `IVMC_NUM_IRQ; i++) begin
            k_val = prio_key(irq_prio_in[i*`IVMC_PRIO_W +: `IVMC_PRIO_W],
                             group_split_in);
            if (pend_q[i] && irq_en_in[i] && k_val < best_key) begin
                best_key = k_val;
                best_num = 7'(i) + `IVMC_IRQ_BASE;
                best_ok = 1'b1;
            end
        end
    end

    // running rank, and the rank left after a handler ends
    always_comb begin
        cur_rank = `IVMC_RANK_IDLE;
        eff_rank = `IVMC_RANK_IDLE;
        if (depth_q != '0) begin
            cur_rank = stk_rank_q[depth_q - DW'(1)];
        end
        if (exc_return_in) begin
            if (depth_q > DW'(1)) begin
                eff_rank = stk_rank_q[depth_q - DW'(2)];
            end
        end else begin
            eff_rank = cur_rank;
        end
    end

    assign offer = best_ok && (best_key[6:3] < eff_rank) && !taken;

    always_comb begin
        if (best_num >= `IVMC_IRQ_BASE) begin
            best_vec = `IVMC_VEC_BASE
                       + {23'h0, 7'(best_num - `IVMC_IRQ_BASE), 2'b00};
        end else begin
            best_vec = {23'h0, best_num, 2'b00};
        end
    end

    // offer follows the best entry until taken, so late arrivals win
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            core_q <= '0;
        end else begin
            core_q.valid <= offer;
            core_q.num <= best_num;
            core_q.vector <= best_vec;
            core_q.tail_chain <= offer && exc_return_in;
        end
    end

    // nesting stack
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            depth_q <= '0;
            for (int d = 0; d < NEST_DEPTH; d++) begin
                stk_num_q[d] <= '0;
                stk_rank_q[d] <= `IVMC_RANK_IDLE;
            end
        end else if (exc_return_in) begin
            if (depth_q != '0) begin
                depth_q <= depth_q - DW'(1);
            end
        end else if (taken && depth_q < DW'(NEST_DEPTH)) begin
            stk_num_q[depth_q] <= core_q.num;
            stk_rank_q[depth_q] <= best_rank_of(core_q.num);
            depth_q <= depth_q + DW'(1);
        end
    end

    // preempting rank of an entry by number
    function automatic logic [`IVMC_RANK_W-1:0] best_rank_of(
        input logic [`IVMC_NUM_W-1:0] n);
        logic [6:0] kk;
        kk = 7'h7f;
        if (n == `IVMC_EXC_NMI) begin
            kk = {`IVMC_RANK_NMI, 3'h0};
        end else if (n == `IVMC_EXC_HARD) begin
            kk = {`IVMC_RANK_HARD, 3'h0};
        end else if (n == `IVMC_EXC_SVC) begin
            kk = prio_key(sys_prio_in[2:0], group_split_in);
        end else if (n == `IVMC_EXC_PEND) begin
            kk = prio_key(sys_prio_in[5:3], group_split_in);
        end else if (n == `IVMC_EXC_TICK) begin
            kk = prio_key(sys_prio_in[8:6], group_split_in);
        end else if (n >= `IVMC_IRQ_BASE) begin
            kk = prio_key(irq_prio_in[6'(n - `IVMC_IRQ_BASE)*`IVMC_PRIO_W +: 3],
                          group_split_in);
        end
        return kk[6:3];
    endfunction

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sys_reset_q <= 1'b0;
        end else begin
            sys_reset_q <= sys_reset_req_in;
        end
    end

    assign core_out = core_q;
    assign nest_depth_out = depth_q;
    assign pending_out = pend_q;
    assign sys_reset_out = sys_reset_q;
endmodule

// [tb/ivmc_nvc_chk.sv]
/* port checker of the nested vectored interrupt controller.
   assumes the bind below onto the top module, one clock domain. */
`timescale 1ns/1ps
module ivmc_nvc_chk #(
    parameter int NEST_DEPTH = 10
) (
    input wire logic                            ref_clk_in,
    input wire logic                            rst_in,
    input wire ivmc_pkg::ivmc_periph_t          periph_in,
    input wire logic [63:0]                     src_en_in,
    input wire logic [63:0]                     irq_en_in,
    input wire logic [63:0]                     sw_pend_set_in,
    input wire logic                            sys_reset_req_in,
    input wire logic                            exc_taken_in,
    input wire logic                            exc_return_in,
    input wire ivmc_pkg::ivmc_core_t            core_out,
    input wire logic [$clog2(NEST_DEPTH+1)-1:0] nest_depth_out,
    input wire logic [63:0]                     pending_out,
    input wire logic                            sys_reset_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    a_reset_copy: assert property (sys_reset_req_in |=> sys_reset_out)
        else $error("reset request not passed on");
    a_sw_pend_set: assert property (|(sw_pend_set_in & 64'h0003_fbf3_3fff_61ef) |=>
        (pending_out & $past(sw_pend_set_in) & 64'h0003_fbf3_3fff_61ef)
        == ($past(sw_pend_set_in) & 64'h0003_fbf3_3fff_61ef))
        else $error("software pend lost");
    a_vector_word: assert property (core_out.valid |->
        core_out.vector == {23'h0, core_out.num, 2'b00}) else $error("vector slot wrong");
    a_rsvd_quiet: assert property ((pending_out & 64'hfffc_040c_c000_9e10) == 64'h0)
        else $error("reserved line pending");
    a_enable_gate: assert property (core_out.valid && core_out.num >= 7'h10 |->
        |($past(irq_en_in) & (64'h1 << (core_out.num - 7'h10)))) else $error("disabled offer");
    a_line_pend: assert property ($rose(periph_in.watchdog_irq & src_en_in[3]) |=>
        pending_out[3]) else $error("watchdog edge not pending");
    a_take_push: assert property (exc_taken_in && core_out.valid && !exc_return_in &&
        nest_depth_out < NEST_DEPTH |=> !core_out.valid &&
        nest_depth_out == $past(nest_depth_out) + 1'b1) else $error("take not pushed");
    a_return_pop: assert property (exc_return_in && nest_depth_out != 0 |=>
        nest_depth_out == $past(nest_depth_out) - 1'b1) else $error("return not popped");
    a_tail_pulse: assert property (core_out.tail_chain |->
        core_out.valid && $past(exc_return_in) ##1 !core_out.tail_chain)
        else $error("tail chain pulse wrong");
    a_nest_bound: assert property (nest_depth_out <= NEST_DEPTH)
        else $error("nesting too deep");
endmodule
bind ivmc_nested_vector_controller ivmc_nvc_chk #(.NEST_DEPTH(NEST_DEPTH)) u_ivmc_nvc_chk (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .periph_in(periph_in),
    .src_en_in(src_en_in), .irq_en_in(irq_en_in), .sw_pend_set_in(sw_pend_set_in),
    .sys_reset_req_in(sys_reset_req_in), .exc_taken_in(exc_taken_in),
    .exc_return_in(exc_return_in), .core_out(core_out), .nest_depth_out(nest_depth_out),
    .pending_out(pending_out), .sys_reset_out(sys_reset_out));

// [tb/ivmc_core_model.sv]
/* processor core model: takes offers after a chosen wait, returns on command.
   assumes the controller's registered offer and one clock. */
`timescale 1ns/1ps
module ivmc_core_model (
    input  wire logic                 ref_clk_in,
    input  wire ivmc_pkg::ivmc_core_t core_in,
    input  wire logic                 take_en_in,
    input  wire logic [3:0]           take_wait_in,
    input  wire logic                 ret_cmd_in,
    output logic                      taken_out,
    output logic                      return_out
);
    logic [3:0] seen_q;
    initial seen_q = 4'h0;
    initial taken_out = 1'b0;
    assign return_out = ret_cmd_in;
    // one-cycle take, not raised on an edge that samples a return command
    always @(posedge ref_clk_in) begin
        seen_q <= core_in.valid ? seen_q + 4'h1 : 4'h0;
        taken_out <= core_in.valid && take_en_in && !taken_out && !ret_cmd_in &&
                     seen_q >= take_wait_in;
    end
endmodule

// [tb/ivmc_nested_vector_controller_tb.sv]
/* testbench of the nested vectored interrupt controller.
   assumes the package, the controller, the core model and the checker. */
`timescale 1ns/1ps
module ivmc_nested_vector_controller_tb;
    localparam int LN[39] = '{0, 1, 2, 3, 5, 6, 7, 8, 13, 14, 16, 17, 18, 19, 20, 21, 22, 23,
        24, 25, 26, 27, 28, 29, 32, 33, 36, 37, 38, 39, 40, 41, 43, 44, 45, 46, 47, 48, 49};
    localparam logic [6:0] SN[5] = '{7'h02, 7'h03, 7'h0b, 7'h0e, 7'h0f};
    logic                   ref_clk_in;
    logic                   rst_in;
    ivmc_pkg::ivmc_periph_t periph;
    ivmc_pkg::ivmc_sys_t    sys;
    ivmc_pkg::ivmc_core_t   core_out;
    logic [63:0]            src_en, irq_en, sw_set, sw_clr, pending_out;
    logic [191:0]           prio;
    logic [1:0]             grp;
    logic [3:0]             nest_depth_out, take_wait;
    logic                   rst_req, sys_reset_out, taken, ret, ret_cmd, take_en;
    int                     compares, miscompares, cycles;
    ivmc_nested_vector_controller u_ivmc_nested_vector_controller (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .periph_in(periph), .src_en_in(src_en),
        .irq_en_in(irq_en), .irq_prio_in(prio), .sys_prio_in(9'h000), .group_split_in(grp),
        .sw_pend_set_in(sw_set), .sw_pend_clr_in(sw_clr), .sys_in(sys),
        .sys_reset_req_in(rst_req), .exc_taken_in(taken), .exc_return_in(ret),
        .core_out(core_out), .nest_depth_out(nest_depth_out), .pending_out(pending_out),
        .sys_reset_out(sys_reset_out));
    ivmc_core_model u_ivmc_core_model (.ref_clk_in(ref_clk_in), .core_in(core_out),
        .take_en_in(take_en), .take_wait_in(take_wait), .ret_cmd_in(ret_cmd),
        .taken_out(taken), .return_out(ret));
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    task automatic pulse_line(input int b);
        periph[b] = 1'b1;
        cyc(1);
        periph[b] = 1'b0;
    endtask
    task automatic do_ret;
        ret_cmd = 1'b1;
        cyc(1);
        ret_cmd = 1'b0;
    endtask
    task automatic do_take;
        take_en = 1'b1;
        cyc(2);
        take_en = 1'b0;
    endtask
    // waits for the named offer, then checks slot and tail flag
    task automatic offer(input logic [6:0] n, input logic tc);
        for (int i = 0; i < 20 && !(core_out.valid === 1'b1 && core_out.num === n); i++) cyc(1);
        chk("offer num", {57'h0, n}, {57'h0, core_out.num});
        chk("offer vector", {55'h0, n, 2'b00}, {32'h0, core_out.vector});
        chk("tail chain", {63'h0, tc}, {63'h0, core_out.tail_chain});
    endtask
    task automatic test_map;
        take_en = 1'b1;
        for (int b = 0; b < 39; b++) begin
            pulse_line(b);
            cyc(1);
            chk("line pending", 64'h1 << LN[b], pending_out);
            offer(7'h10 + 7'(LN[b]), 1'b0);
            cyc(2);
            do_ret;
            cyc(2);
            chk("pending cleared", 64'h0, pending_out);
        end
        $display("test map done");
    endtask
    task automatic test_gate;
        src_en[3] = 1'b0;
        pulse_line(3);
        cyc(3);
        chk("masked source", 64'h0, pending_out);
        src_en[3] = 1'b1;
        irq_en[3] = 1'b0;
        pulse_line(3);
        cyc(4);
        chk("disabled pend", 64'h8, pending_out);
        chk("disabled offer", 64'h0, {63'h0, core_out.valid});
        sw_clr[3] = 1'b1;
        cyc(1);
        sw_clr[3] = 1'b0;
        chk("sw clear", 64'h0, pending_out);
        irq_en[3] = 1'b1;
        sw_set[40] = 1'b1;
        sw_set[4] = 1'b1;
        rst_req = 1'b1;
        cyc(1);
        sw_set[40] = 1'b0;
        sw_set[4] = 1'b0;
        rst_req = 1'b0;
        chk("reserved set", 64'h1 << 40, pending_out);
        chk("reset request", 64'h1, {63'h0, sys_reset_out});
        offer(7'h38, 1'b0);
        cyc(2);
        do_ret;
        cyc(2);
        $display("test gate done");
    endtask
    task automatic test_sys;
        take_wait = 4'h3;
        for (int i = 0; i < 5; i++) begin
            sys[i] = 1'b1;
            cyc(1);
            sys[i] = 1'b0;
            offer(SN[i], 1'b0);
            cyc(6);
            do_ret;
            cyc(2);
        end
        take_wait = 4'h0;
        $display("test sys done");
    endtask
    task automatic test_nest;
        take_en = 1'b0;
        prio[15+:12] = 12'h24e;
        pulse_line(4);
        offer(7'h15, 1'b0);
        pulse_line(5);
        offer(7'h16, 1'b0);
        do_take;
        cyc(3);
        chk("no preempt", 64'h0, {63'h0, core_out.valid});
        chk("depth", 64'h1, 64'(nest_depth_out));
        do_ret;
        offer(7'h15, 1'b1);
        do_take;
        do_ret;
        cyc(2);
        grp = 2'h3;
        periph[7:6] = 2'b11;
        cyc(1);
        periph[7:6] = 2'b00;
        offer(7'h17, 1'b0);
        do_take;
        pulse_line(5);
        cyc(3);
        chk("same group", 64'h0, {63'h0, core_out.valid});
        do_ret;
        offer(7'h16, 1'b1);
        take_en = 1'b1;
        cyc(3);
        do_ret;
        cyc(4);
        do_ret;
        cyc(3);
        chk("all served", 64'h0, pending_out | 64'(nest_depth_out));
        $display("test nest done");
    endtask
    task automatic end_sim;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            end_sim;
        end
    end
    initial begin
        {periph, sys, sw_set, sw_clr, prio, grp, rst_req, ret_cmd, take_en} = '0;
        {src_en, irq_en, take_wait, rst_in} = {128'hffff_ffff_ffff_ffff_ffff_ffff_ffff_ffff,
                                               4'h0, 1'b1};
        cyc(5);
        chk("reset state", 64'h0, {24'h0, core_out} | pending_out | 64'(nest_depth_out));
        rst_in = 1'b0;
        cyc(1);
        test_map;
        test_gate;
        test_sys;
        test_nest;
        end_sim;
    end
endmodule
